// file: design/evp_consts.vh
`ifndef EVP_CONSTS_VH
`define EVP_CONSTS_VH
// How it works
// RULE_01 - peripheral line n uses bit n everywhere and exception number n plus 16
// RULE_02 - handler address word sits at base plus four times exception number
// RULE_03 - table word zero holds initial stack pointer, later words hold handlers
// RULE_04 - software sets bit zero of every handler address in the table
// RULE_05 - table base is zero after reset until relocated
// RULE_06 - base may move within 0x100..0x3FFFFF00; later vectors use new base
// RULE_07 - base written by software is 256-byte aligned; low eight bits read zero
// RULE_08 - smaller priority value wins
// RULE_09 - reset, hard fault and NMI have fixed levels; all others programmable
// RULE_10 - programmable levels are three bits, 0 to 7, below all fixed levels
// RULE_11 - programmable levels reset to zero
// RULE_12 - equal best priorities resolve to the smallest exception number
// RULE_13 - preempt only when pending priority is strictly better than active
// RULE_14 - equal priority to running handler stays pending, no preemption
// RULE_15 - system exceptions versus peripheral service routines are flagged apart
// RULE_16 - fixed levels are -3 reset, -2 NMI, -1 hard fault
// RULE_17 - reserved lines never pend; their enable and priority read zero
// RULE_18 - winner and preemption decision re-evaluated every clock cycle

// -----------------------------------------------------------------
// numbering and table
// -----------------------------------------------------------------
`define EVP_NUM_LINES 44
`define EVP_IRQ_BASE 7'h10
`define EVP_EXC_RESET 7'h01
`define EVP_EXC_NMI 7'h02
`define EVP_EXC_HARD 7'h03
`define EVP_EXC_MEM 7'h04
`define EVP_EXC_BUS 7'h05
`define EVP_EXC_USAGE 7'h06
`define EVP_EXC_SVC 7'h0B
`define EVP_EXC_DBG 7'h0C
`define EVP_EXC_PENDABLE_SERVICE_REQUEST 7'h0E
`define EVP_EXC_TICK 7'h0F
`define EVP_BASE_RESET 32'h00000000
`define EVP_BASE_MIN 32'h00000100
`define EVP_BASE_MAX 32'h3FFFFF00
`define EVP_BASE_ALIGN_BITS 8
// reserved peripheral lines: 9, 12, 14-17, 32, 34, 37-41
`define EVP_RESERVED_MASK 44'h3E5_0003_D200

// -----------------------------------------------------------------
// priorities (4-bit signed, except the 3-bit programmable reset value)
// -----------------------------------------------------------------
`define EVP_PRI_RESET 4'hD
`define EVP_PRI_NMI 4'hE
`define EVP_PRI_HARD 4'hF
`define EVP_PRI_PROG_RESET 3'h0
`define EVP_PRI_IDLE 4'h8
`endif

// file: design/evp_pick.v
// compares two candidates; smaller priority wins, tie to smaller number
module evp_pick (
  input wire a_valid,
  input wire [3:0] a_pri,
  input wire [6:0] a_num,
  input wire b_valid,
  input wire [3:0] b_pri,
  input wire [6:0] b_num,
  output wire o_valid,
  output wire [3:0] o_pri,
  output wire [6:0] o_num
);
  wire a_wins;
  assign a_wins = a_valid && (!b_valid ||
                  ($signed(a_pri) < $signed(b_pri)) || // [RULE_08]
                  ((a_pri == b_pri) && (a_num < b_num))); // [RULE_12]
  assign o_valid = a_valid | b_valid;
  assign o_pri = a_wins ? a_pri : b_pri;
  assign o_num = a_wins ? a_num : b_num;
endmodule // evp_pick

// file: design/evp_vector_priority.v
`include "evp_consts.vh"

module evp_vector_priority #(
  parameter NUM_LINES = `EVP_NUM_LINES
) (
  input wire MCLK,
  input wire RESETN,
  input wire [NUM_LINES-1:0] PERIPHERAL_INTERRUPT_LINE,
  input wire [NUM_LINES-1:0] IRQ_ENABLE_SET,
  input wire [NUM_LINES-1:0] IRQ_ENABLE_CLR,
  input wire [NUM_LINES-1:0] IRQ_PEND_CLR,
  input wire PRI_WRITE,
  input wire [6:0] PRI_WRITE_NUM,
  input wire [2:0] PRI_WRITE_VALUE,
  input wire VTOR_WRITE,
  input wire [31:0] VTOR_WRITE_DATA,
  input wire NMI_REQ,
  input wire HARD_FAULT_REQ,
  input wire MEM_FAULT_REQ,
  input wire BUS_FAULT_REQ,
  input wire USAGE_FAULT_REQ,
  input wire SUPERVISOR_CALL_EXCEPTION,
  input wire DEBUG_MON_REQ,
  input wire PENDABLE_SERVICE_REQUEST,
  input wire SYSTICK_REQ,
  input wire ACK,
  input wire [6:0] ACK_NUM,
  input wire HANDLER_ACTIVE,
  input wire [6:0] ACTIVE_NUM,
  output reg [NUM_LINES-1:0] IRQ_ENABLE,
  output reg [NUM_LINES-1:0] IRQ_PENDING,
  output reg [3*NUM_LINES-1:0] INTERRUPT_PRIORITY_REGS,
  output reg [23:0] SYSTEM_HANDLER_PRIORITY_REG,
  output reg [31:0] VECTOR_TABLE_BASE_REG,
  output wire [31:0] STACK_INIT_ADDR,
  output wire EXC_VALID,
  output wire [6:0] EXC_NUM,
  output wire [3:0] EXC_PRI,
  output wire [31:0] EXC_VECTOR_ADDR,
  output wire EXC_IS_SYSTEM,
  output wire EXC_IS_ISR,
  output wire PREEMPT
);
  localparam [NUM_LINES-1:0] RSV = `EVP_RESERVED_MASK;

  // -----------------------------------------------------------------
  // peripheral enable, pending, priority
  // -----------------------------------------------------------------
  wire [NUM_LINES-1:0] next_enable;
  wire [NUM_LINES-1:0] next_pend;
  integer i;

  assign next_enable = ((IRQ_ENABLE | IRQ_ENABLE_SET) & ~IRQ_ENABLE_CLR) & ~RSV; // [RULE_17]
  // a new request beats the clear in the same cycle
  assign next_pend = ((IRQ_PENDING & ~IRQ_PEND_CLR) | PERIPHERAL_INTERRUPT_LINE) & ~RSV; // [RULE_17]

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ_ENABLE <= {NUM_LINES{1'b0}};
      IRQ_PENDING <= {NUM_LINES{1'b0}};
      INTERRUPT_PRIORITY_REGS <= {(3*NUM_LINES){1'b0}}; // [RULE_11]
      SYSTEM_HANDLER_PRIORITY_REG <= 24'h000000; // [RULE_11]
    end else begin
      IRQ_ENABLE <= next_enable;
      IRQ_PENDING <= next_pend;
      for (i = 0; i < NUM_LINES; i = i + 1) begin
        if (ACK && ACK_NUM == i + 16 && !PERIPHERAL_INTERRUPT_LINE[i]) begin
          IRQ_PENDING[i] <= 1'b0;
        end
        if (PRI_WRITE && PRI_WRITE_NUM == i + 16 && !RSV[i]) begin // [RULE_01] [RULE_17]
          INTERRUPT_PRIORITY_REGS[3*i +: 3] <= PRI_WRITE_VALUE; // [RULE_10]
        end
      end
      // system slots: 4,5,6,11,12,14,15 programmable; fixed ones ignore writes
      if (PRI_WRITE) begin // [RULE_09]
        case (PRI_WRITE_NUM)
          `EVP_EXC_MEM: SYSTEM_HANDLER_PRIORITY_REG[2:0] <= PRI_WRITE_VALUE;
          `EVP_EXC_BUS: SYSTEM_HANDLER_PRIORITY_REG[5:3] <= PRI_WRITE_VALUE;
          `EVP_EXC_USAGE: SYSTEM_HANDLER_PRIORITY_REG[8:6] <= PRI_WRITE_VALUE;
          `EVP_EXC_SVC: SYSTEM_HANDLER_PRIORITY_REG[11:9] <= PRI_WRITE_VALUE;
          `EVP_EXC_DBG: SYSTEM_HANDLER_PRIORITY_REG[14:12] <= PRI_WRITE_VALUE;
          `EVP_EXC_PENDABLE_SERVICE_REQUEST: SYSTEM_HANDLER_PRIORITY_REG[17:15] <= PRI_WRITE_VALUE;
          `EVP_EXC_TICK: SYSTEM_HANDLER_PRIORITY_REG[20:18] <= PRI_WRITE_VALUE;
          default: SYSTEM_HANDLER_PRIORITY_REG <= SYSTEM_HANDLER_PRIORITY_REG;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // system exception pending (bit k: nmi,hard,mem,bus,usage,svc,dbg,pendable_service_request/tick)
  // -----------------------------------------------------------------
  wire [8:0] sys_req;
  reg [8:0] sys_pend9;
  integer s;
  assign sys_req = {SYSTICK_REQ, PENDABLE_SERVICE_REQUEST, DEBUG_MON_REQ,
                    SUPERVISOR_CALL_EXCEPTION, USAGE_FAULT_REQ, BUS_FAULT_REQ,
                    MEM_FAULT_REQ, HARD_FAULT_REQ, NMI_REQ};
  wire [6:0] sys_num [0:8];
  assign sys_num[0] = `EVP_EXC_NMI;
  assign sys_num[1] = `EVP_EXC_HARD;
  assign sys_num[2] = `EVP_EXC_MEM;
  assign sys_num[3] = `EVP_EXC_BUS;
  assign sys_num[4] = `EVP_EXC_USAGE;
  assign sys_num[5] = `EVP_EXC_SVC;
  assign sys_num[6] = `EVP_EXC_DBG;
  assign sys_num[7] = `EVP_EXC_PENDABLE_SERVICE_REQUEST;
  assign sys_num[8] = `EVP_EXC_TICK;

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sys_pend9 <= 9'h000;
    end else begin
      for (s = 0; s < 9; s = s + 1) begin
        if (sys_req[s]) begin
          sys_pend9[s] <= 1'b1;
        end else if (ACK && ACK_NUM == sys_num[s]) begin
          sys_pend9[s] <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // candidate table: slot 0..8 system, 9.. peripheral
  // -----------------------------------------------------------------
  localparam M = 9 + NUM_LINES;
  wire [M-1:0] c_valid;
  wire [4*M-1:0] c_pri;
  wire [7*M-1:0] c_num;

  assign c_valid[8:0] = sys_pend9;
  assign c_pri[3:0] = `EVP_PRI_NMI; // [RULE_16]
  assign c_pri[7:4] = `EVP_PRI_HARD; // [RULE_16]
  assign c_pri[11:8] = {1'b0, SYSTEM_HANDLER_PRIORITY_REG[2:0]};
  assign c_pri[15:12] = {1'b0, SYSTEM_HANDLER_PRIORITY_REG[5:3]};
  assign c_pri[19:16] = {1'b0, SYSTEM_HANDLER_PRIORITY_REG[8:6]};
  assign c_pri[23:20] = {1'b0, SYSTEM_HANDLER_PRIORITY_REG[11:9]};
  assign c_pri[27:24] = {1'b0, SYSTEM_HANDLER_PRIORITY_REG[14:12]};
  assign c_pri[31:28] = {1'b0, SYSTEM_HANDLER_PRIORITY_REG[17:15]};
  assign c_pri[35:32] = {1'b0, SYSTEM_HANDLER_PRIORITY_REG[20:18]};

  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_sys
      assign c_num[7*g +: 7] = sys_num[g];
    end
    for (g = 0; g < NUM_LINES; g = g + 1) begin : g_irq
      assign c_valid[9+g] = IRQ_PENDING[g] & IRQ_ENABLE[g];
      assign c_pri[4*(9+g) +: 4] = {1'b0, INTERRUPT_PRIORITY_REGS[3*g +: 3]}; // [RULE_10]
      localparam integer LNUM = `EVP_IRQ_BASE + g;
      assign c_num[7*(9+g) +: 7] = LNUM[6:0]; // [RULE_01]
    end
  endgenerate

  // linear chain of pickers, combinational each cycle
  wire [M:0] r_valid;
  wire [4*M+3:0] r_pri;
  wire [7*M+6:0] r_num;
  assign r_valid[0] = 1'b0;
  assign r_pri[3:0] = `EVP_PRI_IDLE;
  assign r_num[6:0] = 7'h7F;
  generate
    for (g = 0; g < M; g = g + 1) begin : g_chain
      evp_pick u_pick (
        .a_valid(c_valid[g]),
        .a_pri(c_pri[4*g +: 4]),
        .a_num(c_num[7*g +: 7]),
        .b_valid(r_valid[g]),
        .b_pri(r_pri[4*g +: 4]),
        .b_num(r_num[7*g +: 7]),
        .o_valid(r_valid[g+1]),
        .o_pri(r_pri[4*(g+1) +: 4]),
        .o_num(r_num[7*(g+1) +: 7])
      );
    end
  endgenerate

  assign EXC_VALID = r_valid[M]; // [RULE_18]
  assign EXC_NUM = r_valid[M] ? r_num[7*M +: 7] : 7'h00;
  assign EXC_PRI = r_pri[4*M +: 4];

  // -----------------------------------------------------------------
  // priority of the running handler
  // -----------------------------------------------------------------
  reg [3:0] act_pri;
  integer c;
  always @* begin
    act_pri = `EVP_PRI_IDLE;
    for (c = 0; c < M; c = c + 1) begin
      if (c_num[7*c +: 7] == ACTIVE_NUM) begin
        act_pri = c_pri[4*c +: 4];
      end
    end
    if (ACTIVE_NUM == `EVP_EXC_RESET) begin
      act_pri = `EVP_PRI_RESET; // [RULE_16]
    end
  end

  // strictly better only; ties stay pending
  assign PREEMPT = EXC_VALID && HANDLER_ACTIVE &&
                   ($signed(EXC_PRI) < $signed(act_pri)); // [RULE_13] [RULE_14]

  assign EXC_IS_SYSTEM = EXC_VALID && (EXC_NUM < `EVP_IRQ_BASE); // [RULE_15]
  assign EXC_IS_ISR = EXC_VALID && (EXC_NUM >= `EVP_IRQ_BASE); // [RULE_15]

  // -----------------------------------------------------------------
  // vector table base
  // -----------------------------------------------------------------
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      VECTOR_TABLE_BASE_REG <= `EVP_BASE_RESET; // [RULE_05]
    end else if (VTOR_WRITE && VTOR_WRITE_DATA >= `EVP_BASE_MIN &&
                 VTOR_WRITE_DATA <= `EVP_BASE_MAX) begin // [RULE_06]
      VECTOR_TABLE_BASE_REG <= {VTOR_WRITE_DATA[31:`EVP_BASE_ALIGN_BITS],
                                8'h00}; // [RULE_07]
    end
  end

  assign STACK_INIT_ADDR = VECTOR_TABLE_BASE_REG; // [RULE_03]
  assign EXC_VECTOR_ADDR = VECTOR_TABLE_BASE_REG + {23'h000000, EXC_NUM, 2'b00}; // [RULE_02]
endmodule // evp_vector_priority

// file: dv/evp_vector_priority_sva.sv
`include "evp_consts.vh"
// ----
// arbiter port checks
// ----
module evp_sva #(
  parameter NUM_LINES = 44
) (
  input wire MCLK,
  input wire RESETN,
  input wire [NUM_LINES-1:0] PERIPHERAL_INTERRUPT_LINE,
  input wire VTOR_WRITE,
  input wire [31:0] VTOR_WRITE_DATA,
  input wire HANDLER_ACTIVE,
  input wire [NUM_LINES-1:0] IRQ_ENABLE,
  input wire [NUM_LINES-1:0] IRQ_PENDING,
  input wire [3*NUM_LINES-1:0] INTERRUPT_PRIORITY_REGS,
  input wire [31:0] VECTOR_TABLE_BASE_REG,
  input wire EXC_VALID,
  input wire [6:0] EXC_NUM,
  input wire [3:0] EXC_PRI,
  input wire [31:0] EXC_VECTOR_ADDR,
  input wire EXC_IS_ISR,
  input wire PREEMPT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_line_pend: assert property (PERIPHERAL_INTERRUPT_LINE[0] |=> IRQ_PENDING[0])
    else $error("line 0 did not pend");
  a_vec_addr: assert property (EXC_VALID |->
    EXC_VECTOR_ADDR == VECTOR_TABLE_BASE_REG + {EXC_NUM, 2'b00}) else $error("bad vector");
  a_base_reset: assert property ($rose(RESETN) |-> VECTOR_TABLE_BASE_REG == 0)
    else $error("base not zero");
  a_base_move: assert property (VTOR_WRITE && VTOR_WRITE_DATA >= 32'h100 &&
    VTOR_WRITE_DATA <= 32'h3FFFFF00 |=>
    VECTOR_TABLE_BASE_REG == ($past(VTOR_WRITE_DATA) & 32'hFFFFFF00)) else $error("base lost");
  a_base_hold: assert property (!VTOR_WRITE |=> $stable(VECTOR_TABLE_BASE_REG))
    else $error("base moved");
  a_base_align: assert property (VECTOR_TABLE_BASE_REG[7:0] == 8'h00)
    else $error("base unaligned");
  a_irq_pri: assert property (EXC_VALID && EXC_NUM >= 16 |->
    EXC_PRI == {1'b0, INTERRUPT_PRIORITY_REGS[3*(EXC_NUM-16) +: 3]}) else $error("irq pri");
  a_fixed_pri: assert property (EXC_VALID && EXC_NUM > 0 && EXC_NUM < 4 |->
    EXC_PRI == 4'hC + EXC_NUM[3:0]) else $error("fixed pri");
  a_isr_flag: assert property (EXC_VALID && EXC_NUM >= 16 |-> EXC_IS_ISR)
    else $error("isr flag");
  a_preempt_cause: assert property (PREEMPT |-> HANDLER_ACTIVE && EXC_VALID)
    else $error("stray preempt");
  a_rsv_quiet: assert property (((IRQ_PENDING | IRQ_ENABLE) & `EVP_RESERVED_MASK) == 0)
    else $error("reserved line live");
endmodule // evp_sva

// file: dv/evp_core.sv
// ----
// core side: takes the winner
// ----
module evp_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic take,
  input wire logic slow,
  input wire logic valid,
  input wire logic [6:0] num,
  output logic ack,
  output logic [6:0] ack_num
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] dly;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      ack_num <= 7'h7F;
      dly <= 2'h0;
    end else if (ack || !take || !valid) begin
      ack <= 1'b0;
      ack_num <= ~ack_num; // idle number is junk: the old number inverted, so every other idle cycle repeats it
      dly <= 2'h0;
    end else if (slow && dly != 2'h3) begin
      dly <= dly + 2'h1;
    end else begin
      ack <= 1'b1;
      ack_num <= num; // the table word it fetches has bit zero set by software
    end
  end
endmodule // evp_core

// file: dv/evp_vector_priority_tb.sv
`include "evp_consts.vh"
module evp_vector_priority_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [43:0] RSV = `EVP_RESERVED_MASK;
  logic mclk = 0, rst_n = 0, pw = 0, vw = 0, hact = 0, take = 0, slow = 0;
  logic [43:0] line = 0, en_set = 0, en_clr = 0, pclr = 0, ep, ee;
  logic [15:0] sreq = 0;
  logic [6:0] pwn = 0, anum = 0;
  logic [2:0] pwv = 0;
  logic [31:0] vd = 0, base, r;
  logic [131:0] epr;
  logic [23:0] esh;
  wire ack, valid, isr, preempt, sysf;
  wire [6:0] ack_num, num;
  wire [3:0] xpri;
  wire [31:0] stk, addr, vtb;
  wire [43:0] ien, ipend;
  wire [131:0] ipr;
  wire [23:0] shpr;
  int n_mismatch = 0, samples_checked = 0, pri[0:59], best, win, i, k, j;
  int snum[7] = '{4, 5, 6, 11, 12, 14, 15};
  int vt[5] = '{32'hFF, 32'h100, 32'h12345, 32'h40000000, 32'h3FFFFF00};
  bit pend[0:59], en[0:43];
  always #5 mclk = ~mclk;
  evp_vector_priority dut_u (.MCLK(mclk), .RESETN(rst_n), .PERIPHERAL_INTERRUPT_LINE(line),
    .IRQ_ENABLE_SET(en_set), .IRQ_ENABLE_CLR(en_clr), .IRQ_PEND_CLR(pclr), .PRI_WRITE(pw),
    .PRI_WRITE_NUM(pwn), .PRI_WRITE_VALUE(pwv), .VTOR_WRITE(vw), .VTOR_WRITE_DATA(vd),
    .NMI_REQ(sreq[2]), .HARD_FAULT_REQ(sreq[3]), .MEM_FAULT_REQ(sreq[4]), .BUS_FAULT_REQ(sreq[5]),
    .USAGE_FAULT_REQ(sreq[6]), .SUPERVISOR_CALL_EXCEPTION(sreq[11]), .DEBUG_MON_REQ(sreq[12]),
    .PENDABLE_SERVICE_REQUEST(sreq[14]), .SYSTICK_REQ(sreq[15]), .ACK(ack), .ACK_NUM(ack_num),
    .HANDLER_ACTIVE(hact), .ACTIVE_NUM(anum), .IRQ_ENABLE(ien), .IRQ_PENDING(ipend),
    .INTERRUPT_PRIORITY_REGS(ipr), .SYSTEM_HANDLER_PRIORITY_REG(shpr),
    .VECTOR_TABLE_BASE_REG(vtb), .STACK_INIT_ADDR(stk), .EXC_VALID(valid), .EXC_NUM(num),
    .EXC_PRI(xpri), .EXC_VECTOR_ADDR(addr), .EXC_IS_SYSTEM(sysf), .EXC_IS_ISR(isr),
    .PREEMPT(preempt));
  evp_core core_u (.clk(mclk), .rst_n(rst_n), .take(take), .slow(slow), .valid(valid),
    .num(num), .ack(ack), .ack_num(ack_num));
  task automatic check(string what, logic [131:0] seen, logic [131:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----
  // reference model: state moves on the edge, outputs judged mid-cycle
  // ----
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      foreach (pri[k]) pri[k] = (k > 0 && k < 4) ? k - 4 : 0;
      foreach (pend[k]) pend[k] = 0;
      foreach (en[k]) en[k] = 0;
      base = 0;
    end else begin
      for (k = 0; k < 60; k++) begin
        if (ack && ack_num == k || k > 15 && pclr[k-16]) pend[k] = 0;
        if (k < 16 ? sreq[k] : line[k-16] && !RSV[k-16]) pend[k] = 1;
        if (k < 44 && en_set[k] && !RSV[k]) en[k] = 1;
        if (k < 44 && en_clr[k]) en[k] = 0;
      end
      if (pw && (pwn inside {4, 5, 6, 11, 12, 14, 15} || pwn > 15 && pwn < 60 && !RSV[pwn-16]))
        pri[pwn] = pwv;
      if (vw && vd >= 32'h100 && vd <= 32'h3FFFFF00) base = vd & 32'hFFFFFF00;
    end
  end
  always @(negedge mclk) if (rst_n) begin
    best = 99;
    win = 0;
    for (i = 1; i < 60; i++) if (pend[i] && (i < 16 || en[i-16]) && pri[i] < best) begin
      best = pri[i];
      win = i;
    end
    for (i = 0; i < 44; i++) begin
      ep[i] = pend[i+16];
      ee[i] = en[i];
      epr[3*i +: 3] = 3'(pri[i+16]);
      if (i < 7) esh[3*i +: 3] = 3'(pri[snum[i]]);
    end
    esh[23:21] = 3'h0;
    check("valid", valid, win != 0);
    if (win != 0) begin
      check("num", num, win);
      check("pri", xpri, best[3:0]);
      check("addr", addr, base + 4 * win);
      check("isr", isr, win > 15);
    end
    check("system", sysf, win != 0 && win < 16);
    check("preempt", preempt, hact && win != 0 && best < pri[anum]);
    check("base", vtb, base);
    check("stack", stk, base);
    check("pending", ipend, ep);
    check("enable", ien, ee);
    check("irq pri", ipr, epr);
    check("sys pri", shpr, esh);
  end
  initial begin
    void'($urandom(38629));
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    en_set <= '1;
    @(posedge mclk);
    en_set <= 0;
    line <= 44'h3; // equal levels, lower number must win
    @(posedge mclk);
    line <= 0;
    for (j = 0; j < 4 && valid !== 1'b1; j++) @(negedge mclk);
    if (valid !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    @(posedge mclk);
    for (j = 0; j < 60; j++) begin
      pw <= 1; // fixed and reserved numbers must be ignored
      pwn <= 7'(j);
      pwv <= 3'($urandom);
      @(posedge mclk);
    end
    pw <= 0;
    foreach (vt[j]) begin
      vw <= 1; // in-range values take with low byte cleared
      vd <= vt[j];
      @(posedge mclk);
    end
    vw <= 0;
    take <= 1;
    repeat (2000) begin
      @(posedge mclk);
      r = $urandom;
      line <= 44'(r[5:0] == 0) << r[13:8];
      sreq <= (16'(r[9:7] == 0) << r[19:16]) & 16'hD87C;
      pclr <= 44'(r[22:20] == 0) << r[29:24];
      en_set <= 44'(r[23]) << r[29:24];
      en_clr <= r[13:8] == r[29:24] ? 44'h0 : 44'(r[31:30] == 0) << r[13:8];
      slow <= r[3];
      pw <= r[27:25] == 0;
      pwn <= 7'(r[22:16] % 60);
      pwv <= r[2:0];
      hact <= r[15:12] == 0 ? r[11] : hact;
      anum <= r[7] ? 7'(r[6:4] % 6 + 1) : 7'(16 + r[13:8] % 44);
    end
    @(posedge mclk);
    {line, sreq, pclr, en_set, en_clr, pw, hact} <= '0;
    rst_n <= 0; // mid-run reset: relocated base and pending state must clear
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    line <= 44'h1; // first request right after release must pend
    @(posedge mclk);
    line <= 0;
    repeat (4) @(posedge mclk);
    wrap_up();
  end
endmodule // evp_vector_priority_tb
bind evp_vector_priority evp_sva #(.NUM_LINES(NUM_LINES)) sva_u (.MCLK, .RESETN,
  .PERIPHERAL_INTERRUPT_LINE, .VTOR_WRITE, .VTOR_WRITE_DATA, .HANDLER_ACTIVE, .IRQ_ENABLE,
  .IRQ_PENDING, .INTERRUPT_PRIORITY_REGS, .VECTOR_TABLE_BASE_REG, .EXC_VALID, .EXC_NUM,
  .EXC_PRI, .EXC_VECTOR_ADDR, .EXC_IS_ISR, .PREEMPT);
